// ---- design/fec_core.sv ----
// Frequency error measurement, correction, temperature and receive timeouts
// Contract
// - Measured frequency error is stored signed in freq_error_result_reg.
// - A measurement takes four bit periods from launch to result.
// - Finished correction subtracts measured error from carrier frequency and adds it to correction value.
// - With auto enable set, correction starts on each receiver enable.
// - With auto enable clear, correction_start triggers exactly one correction.
// - Auto correction clears previous value first when auto-clear is set.
// - Correction phase selects the correction bandwidth instead of normal bandwidth.
// - Low-index mode corrects by error plus offset times 488 Hz.
// - Temperature runs only in standby or synthesizer mode, receiver chain off for the whole conversion; the code checks the mode at start only.
// - Temperature reading falls one LSB per degree rise.
// - Temperature done and running flag cleared within 100 microseconds.
// - Timeout if signal flag not risen within rx_start_timeout times 16 bits.
// - Timeout once post_threshold_timeout times 16 bits after signal flag rose.
`timescale 1ns/1ps
`default_nettype none
module fec_core #(
  parameter int TEMP_CYC = fec_pkg::TEMP_CONV_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] op_mode,
  input wire logic bit_tick,
  input wire logic meas_start,
  input wire logic signed [fec_pkg::ERR_W-1:0] raw_error,
  input wire logic auto_correct_enable,
  input wire logic correction_start,
  input wire logic auto_clear_enable,
  input wire logic low_index_correct_enable,
  input wire logic [fec_pkg::OFFS_W-1:0] low_index_offset,
  input wire logic [fec_pkg::FREQ_W-1:0] carrier_wr_data,
  input wire logic carrier_wr,
  input wire logic temp_start,
  input wire logic [fec_pkg::TEMP_W-1:0] temp_sensor_code,
  input wire logic [fec_pkg::TOUT_W-1:0] rx_start_timeout,
  input wire logic [fec_pkg::TOUT_W-1:0] post_threshold_timeout,
  input wire logic signal_level_flag,
  output logic signed [fec_pkg::ERR_W-1:0] freq_error_result,
  output logic signed [fec_pkg::ERR_W-1:0] correction_value,
  output logic [fec_pkg::FREQ_W-1:0] carrier_freq,
  output logic correction_bw_sel,
  output logic meas_busy,
  output logic meas_done,
  output logic temp_running,
  output logic [fec_pkg::TEMP_W-1:0] temp_value,
  output logic rx_chain_off,
  output logic timeout_irq
);
  import fec_pkg::*;

  function automatic logic signed [ERR_W-1:0] offs_steps(input logic [OFFS_W-1:0] o);
    // Offset in synth steps: o * 488 / 61, which is exactly o * 8
    offs_steps = ERR_W'(signed'({1'b0, o}) * (LOW_INDEX_STEP_HZ / FSTEP_HZ));
  endfunction : offs_steps

  fec_state_t state_reg, state_next;
  logic [2:0] mode_q_reg;
  logic [2:0] bits_reg, bits_next;
  logic corr_reg, corr_next;
  logic signed [ERR_W-1:0] fei_reg, corr_val_reg;
  logic [FREQ_W-1:0] frf_reg;
  logic in_rx, rx_entry, auto_go, man_go, go_corr, go_any, meas_last, abort;
  logic signed [ERR_W-1:0] step_err, base_corr, new_corr;
  logic temp_ok, temp_go;
  logic [$clog2(TEMP_LIMIT_CYC+1)-1:0] temp_cnt_reg;
  logic [TEMP_W-1:0] temp_reg;
  logic temp_run_reg, chain_off_reg;
  logic [TOUT_W+4:0] tout_cnt_reg;
  logic sig_q_reg, sig_seen_reg, irq_reg, busy_reg, done_reg, bw_reg;
  logic sig_rise, tout_hit, tout_armed;
  logic [TOUT_W+4:0] tout_limit;

  assign in_rx = (op_mode == MODE_RX);
  assign rx_entry = in_rx && (mode_q_reg != MODE_RX);
  assign abort = !in_rx;
  assign auto_go = rx_entry && auto_correct_enable;
  assign man_go = in_rx && correction_start && !auto_correct_enable;
  assign go_corr = auto_go || man_go;
  assign go_any = go_corr || (in_rx && meas_start);
  assign meas_last = bit_tick && (bits_reg == 3'(MEAS_BITS - 1));
  // Stored result, so a fresh sample in the apply cycle cannot leak in
  assign step_err = low_index_correct_enable ? ERR_W'(fei_reg + offs_steps(low_index_offset))
                                             : fei_reg;
  assign base_corr = (auto_go && auto_clear_enable) ? ERR_RESET : corr_val_reg;
  assign new_corr = ERR_W'(corr_val_reg + step_err);

  always_comb begin
    state_next = state_reg;
    bits_next = bits_reg;
    corr_next = corr_reg;
    case (state_reg)
      FEC_IDLE: begin
        if (go_any) begin
          state_next = FEC_MEAS;
          bits_next = 3'h0;
          corr_next = go_corr;
        end
      end
      FEC_MEAS: begin
        if (abort) begin
          state_next = FEC_IDLE;
        end else if (meas_last) begin
          state_next = corr_reg ? FEC_APPLY : FEC_IDLE;
        end else if (bit_tick) begin
          bits_next = 3'(bits_reg + 3'h1);
        end
      end
      default: begin
        state_next = FEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= FEC_IDLE;
      bits_reg <= 3'h0;
      corr_reg <= 1'b0;
      mode_q_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      bits_reg <= bits_next;
      corr_reg <= corr_next;
      mode_q_reg <= op_mode;
    end
  end

  // Measurement result and correction bookkeeping
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fei_reg <= ERR_RESET;
      corr_val_reg <= ERR_RESET;
      frf_reg <= FREQ_RESET;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      bw_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      busy_reg <= (state_next == FEC_MEAS);
      bw_reg <= (state_next == FEC_MEAS) && corr_next;
      if (state_reg == FEC_IDLE && go_any) begin
        corr_val_reg <= base_corr;
        if (auto_go && auto_clear_enable) begin
          frf_reg <= FREQ_W'(frf_reg + FREQ_W'(corr_val_reg));
        end
      end
      if (state_reg == FEC_MEAS && !abort && meas_last) begin
        fei_reg <= raw_error;
        done_reg <= 1'b1;
      end
      if (state_reg == FEC_APPLY) begin
        corr_val_reg <= new_corr;
        frf_reg <= FREQ_W'(frf_reg - FREQ_W'(step_err));
      end else if (carrier_wr) begin
        frf_reg <= carrier_wr_data;
      end
    end
  end

  // Temperature: conversion bounded far below the 100 us limit
  assign temp_ok = (op_mode == MODE_STANDBY) || (op_mode == MODE_SYNTH);
  assign temp_go = temp_start && temp_ok && !temp_run_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      temp_run_reg <= 1'b0;
      chain_off_reg <= 1'b0;
      temp_cnt_reg <= '0;
      temp_reg <= TEMP_RESET;
    end else if (temp_go) begin
      temp_run_reg <= 1'b1;
      chain_off_reg <= 1'b1;
      temp_cnt_reg <= '0;
    end else if (temp_run_reg) begin
      temp_cnt_reg <= temp_cnt_reg + 1'b1;
      if (temp_cnt_reg == $bits(temp_cnt_reg)'(TEMP_CYC - 1)) begin
        temp_run_reg <= 1'b0;
        chain_off_reg <= 1'b0;
        temp_reg <= ~temp_sensor_code;
      end
    end
  end

  // Timeouts count bit ticks; sticky irq cleared by leaving receive mode
  assign sig_rise = signal_level_flag && !sig_q_reg;
  assign tout_limit = sig_seen_reg ? {1'b0, post_threshold_timeout, 4'h0}
                                   : {1'b0, rx_start_timeout, 4'h0};
  assign tout_armed = (tout_limit != '0) && !irq_reg;
  assign tout_hit = tout_armed && bit_tick && (tout_cnt_reg == (TOUT_W+5)'(tout_limit - 1'b1));

  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      tout_cnt_reg <= '0;
      sig_q_reg <= 1'b0;
      sig_seen_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      sig_q_reg <= signal_level_flag;
      if (sig_rise && !sig_seen_reg) begin
        sig_seen_reg <= 1'b1;
        tout_cnt_reg <= '0;
      end else if (tout_hit) begin
        irq_reg <= 1'b1;
      end else if (tout_armed && bit_tick) begin
        tout_cnt_reg <= tout_cnt_reg + 1'b1;
      end
    end
  end

  assign freq_error_result = fei_reg;
  assign correction_value = corr_val_reg;
  assign carrier_freq = frf_reg;
  assign correction_bw_sel = bw_reg;
  assign meas_busy = busy_reg;
  assign meas_done = done_reg;
  assign temp_running = temp_run_reg;
  assign temp_value = temp_reg;
  assign rx_chain_off = chain_off_reg;
  assign timeout_irq = irq_reg;

  int temp_age;
  always_ff @(posedge core_clk) begin
    if (srst || !temp_run_reg) begin
      temp_age <= 0;
    end else begin
      temp_age <= temp_age + 1;
    end
  end

  // Independent tick count, so meas_ticks_a does not trust bits_reg
  int meas_ticks;
  always_ff @(posedge core_clk) begin
    if (srst || state_reg != FEC_MEAS) begin
      meas_ticks <= 0;
    end else if (bit_tick) begin
      meas_ticks <= meas_ticks + 1;
    end
  end

  // Ticks since receive entry or first threshold rise, apart from tout_cnt_reg
  int tout_ticks;
  always_ff @(posedge core_clk) begin
    if (srst || abort || (sig_rise && !sig_seen_reg)) begin
      tout_ticks <= 0;
    end else if (bit_tick) begin
      tout_ticks <= tout_ticks + 1;
    end
  end

  sequence meas_launch_s;
    state_reg == FEC_IDLE && go_any;
  endsequence
  sequence meas_end_s;
    state_reg == FEC_MEAS && !abort && meas_last;
  endsequence

  meas_result_a: assert property (@(posedge core_clk) disable iff (srst)
    meas_end_s |=> freq_error_result == $past(raw_error))
    else $error("result not stored");
  meas_len_a: assert property (@(posedge core_clk) disable iff (srst)
    meas_done |-> bits_reg == 3'(MEAS_BITS - 1))
    else $error("measurement length wrong");
  corr_sub_a: assert property (@(posedge core_clk) disable iff (srst || carrier_wr)
    state_reg == FEC_APPLY |=> carrier_freq == $past(frf_reg) - FREQ_W'($past(step_err)))
    else $error("carrier not corrected");
  auto_start_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == FEC_IDLE && auto_go) |=> state_reg == FEC_MEAS && corr_reg)
    else $error("auto correction missed");
  manual_start_a: assert property (@(posedge core_clk) disable iff (srst)
    (meas_launch_s and (corr_next && auto_correct_enable && !rx_entry)) |-> 1'b0)
    else $error("correction without trigger");
  auto_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == FEC_IDLE && auto_go && auto_clear_enable) |=> correction_value == ERR_RESET)
    else $error("clear not applied");
  bw_sel_a: assert property (@(posedge core_clk) disable iff (srst)
    correction_bw_sel |-> $past(corr_next))
    else $error("bandwidth select wrong");
  temp_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(temp_running) |-> $past(temp_ok))
    else $error("temperature in wrong mode");
  temp_limit_a: assert property (@(posedge core_clk) disable iff (srst)
    temp_age <= TEMP_LIMIT_CYC)
    else $error("temperature too slow");
  rx_abort_a: assert property (@(posedge core_clk) disable iff (srst)
    abort |=> !timeout_irq && tout_cnt_reg == '0)
    else $error("timeout not abandoned");
  meas_ticks_a: assert property (@(posedge core_clk) disable iff (srst)
    meas_done |-> meas_ticks == MEAS_BITS)
    else $error("measurement tick count wrong");
  low_index_a: assert property (@(posedge core_clk) disable iff (srst || carrier_wr)
    (state_reg == FEC_APPLY && low_index_correct_enable) |=> carrier_freq == FREQ_W'(
      $past(frf_reg) - FREQ_W'($past(freq_error_result))
      - FREQ_W'($past(low_index_offset)) * FREQ_W'(LOW_INDEX_STEP_HZ / FSTEP_HZ)))
    else $error("low index offset not applied");
  temp_invert_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(temp_running) |-> temp_value == ~$past(temp_sensor_code))
    else $error("temperature reading not inverted");
  tout_rx_a: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(timeout_irq) && !sig_seen_reg) |-> tout_ticks == TOUT_BITS_PER_STEP * int'(rx_start_timeout))
    else $error("start timeout length wrong");
  tout_post_a: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(timeout_irq) && sig_seen_reg) |-> tout_ticks == TOUT_BITS_PER_STEP * int'(post_threshold_timeout))
    else $error("threshold timeout length wrong");
endmodule : fec_core
`default_nettype wire

// ---- pkg/fec_pkg.sv ----
// Constants for the frequency error, correction, temperature and timeout block
package fec_pkg;
  localparam int FREQ_W = 24;
  localparam int ERR_W = 16;
  localparam int OFFS_W = 8;
  localparam int TEMP_W = 8;
  localparam int TOUT_W = 8;
  localparam int MEAS_BITS = 4;
  localparam int TOUT_BITS_PER_STEP = 16;
  localparam int LOW_INDEX_STEP_HZ = 488;
  localparam int FSTEP_HZ = 61;
  localparam int TEMP_LIMIT_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int TEMP_LIMIT_CYC = TEMP_LIMIT_US * CLK_MHZ;
  localparam int TEMP_CONV_CYC = 64;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 24'h00_0000;
  localparam logic [ERR_W-1:0] ERR_RESET = 16'h0000;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 8'h00;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h4;
  typedef enum logic [1:0] {FEC_IDLE, FEC_MEAS, FEC_APPLY} fec_state_t;
endpackage : fec_pkg

// ---- verif/fec_host_model.sv ----
// Host side model: bit clock and error samples
`timescale 1ns/1ps
`default_nettype none
module fec_host_model #(
  parameter int BIT_CYC = 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] err_in,
  output logic bit_tick,
  output logic [15:0] raw_error
);
  int cnt;
  // Fresh sample every core clock; bit tick every BIT_CYC clocks
  always_ff @(posedge core_clk) begin
    cnt <= (srst || cnt == BIT_CYC - 1) ? 0 : cnt + 1;
    bit_tick <= !srst && cnt == BIT_CYC - 1;
    raw_error <= err_in;
  end
  // Value a host writes for 500/600 kbps
  localparam logic [7:0] SYNTH_TEST = 8'h0C;
endmodule : fec_host_model
`default_nettype wire

// ---- verif/fec_core_tb_top.sv ----
// Self-checking bench for the correction block
`timescale 1ns/1ps
`default_nettype none
module fec_core_tb_top;
  import fec_pkg::*;
  localparam int TCYC = 40;
  logic core_clk, srst, bit_tick, meas_start, auto_on, c_start, clr_on, low_on;
  logic c_wr, t_start, flag, bw_sel, busy, done, t_run, chain_off, irq, sel_seen;
  logic [2:0] op_mode;
  logic [7:0] offs, t_code, to_rx, to_post, t_val;
  logic [15:0] err, raw, f_res, c_val;
  logic [23:0] freq;
  int n_errors, checks_done, n;
  fec_host_model host (.core_clk(core_clk), .srst(srst), .err_in(err),
    .bit_tick(bit_tick), .raw_error(raw));
  fec_core #(.TEMP_CYC(TCYC)) dut (.core_clk(core_clk), .srst(srst), .op_mode(op_mode),
    .bit_tick(bit_tick), .meas_start(meas_start), .raw_error(raw),
    .auto_correct_enable(auto_on), .correction_start(c_start), .auto_clear_enable(clr_on),
    .low_index_correct_enable(low_on), .low_index_offset(offs),
    .carrier_wr_data(24'h10_0000), .carrier_wr(c_wr), .temp_start(t_start),
    .temp_sensor_code(t_code), .rx_start_timeout(to_rx), .post_threshold_timeout(to_post),
    .signal_level_flag(flag), .freq_error_result(f_res), .correction_value(c_val),
    .carrier_freq(freq), .correction_bw_sel(bw_sel), .meas_busy(busy), .meas_done(done),
    .temp_running(t_run), .temp_value(t_val), .rx_chain_off(chain_off), .timeout_irq(irq));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // Counts bit ticks until done; bounded so a hang shows
  task automatic wait_done(output int ticks);
    int k;
    ticks = 0;
    sel_seen = 0;
    for (k = 0; k < 200 && done !== 1'b1; k++) begin
      @(negedge core_clk);
      if (bit_tick === 1'b1) ticks++;
      if (bw_sel === 1'b1) sel_seen = 1;
    end
    @(negedge core_clk);
  endtask : wait_done
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    srst = 1;
    {meas_start, auto_on, c_start, clr_on, low_on, c_wr, t_start, flag} = '0;
    {offs, t_code, to_rx, to_post} = '0;
    err = 16'hFFF6;
    op_mode = MODE_STANDBY;
    cyc(4);
    srst <= 0;
    cyc(1);
    chk({f_res, busy, t_run, irq}, '0);
    c_wr <= 1;
    cyc(1);
    c_wr <= 0;
    op_mode <= MODE_RX;
    cyc(3);
    c_start <= 1;
    cyc(1);
    c_start <= 0;
    wait_done(n);
    chk(24'(n), 24'(MEAS_BITS));
    chk(f_res, 24'h00_FFF6);
    chk(24'(sel_seen), 24'h00_0001);
    @(negedge core_clk);
    chk(freq, 24'h10_000A);
    cyc(60);
    chk(24'(bw_sel), 24'h00_0000);
    chk(freq, 24'h10_000A);
    $display("manual correction test done");
    op_mode <= MODE_STANDBY;
    auto_on <= 1;
    low_on <= 1;
    offs <= 8'h02;
    err <= 16'h0004;
    cyc(3);
    op_mode <= MODE_RX;
    wait_done(n);
    @(negedge core_clk);
    chk(freq, 24'h0F_FFF6);
    cyc(1);
    op_mode <= MODE_STANDBY;
    clr_on <= 1;
    low_on <= 0;
    err <= 16'h0003;
    cyc(3);
    op_mode <= MODE_RX;
    wait_done(n);
    @(negedge core_clk);
    chk(24'(c_val), 24'h00_0003);
    chk(freq, 24'h0F_FFFD);
    $display("auto correction test done");
    cyc(1);
    auto_on <= 0;
    err <= 16'h0020;
    meas_start <= 1;
    cyc(1);
    meas_start <= 0;
    wait_done(n);
    chk(f_res, 24'h00_0020);
    chk(24'(sel_seen), 24'h00_0000);
    @(negedge core_clk);
    chk(freq, 24'h0F_FFFD);
    chk(24'(c_val), 24'h00_0003);
    $display("plain measurement test done");
    cyc(1);
    t_code <= 8'h35;
    t_start <= 1;
    cyc(1);
    t_start <= 0;
    cyc(3);
    chk(24'(t_run), 24'h00_0000);
    op_mode <= MODE_STANDBY;
    cyc(2);
    t_start <= 1;
    cyc(1);
    t_start <= 0;
    cyc(2);
    chk({t_run, chain_off}, 2'h3);
    for (n = 0; n < TEMP_LIMIT_CYC && t_run === 1'b1; n++) cyc(1);
    chk({t_run, t_val}, 9'h0CA);
    $display("temperature test done");
    to_rx <= 8'h01;
    op_mode <= MODE_RX;
    cyc(70);
    chk(24'(irq), 24'h00_0000);
    cyc(25);
    chk(24'(irq), 24'h00_0001);
    op_mode <= MODE_STANDBY;
    cyc(2);
    chk(24'(irq), 24'h00_0000);
    to_rx <= 8'h00;
    to_post <= 8'h01;
    op_mode <= MODE_RX;
    cyc(10);
    flag <= 1;
    cyc(70);
    chk(24'(irq), 24'h00_0000);
    cyc(25);
    chk(24'(irq), 24'h00_0001);
    $display("timeout test done");
    close_out();
  end
endmodule : fec_core_tb_top
`default_nettype wire
